// file: rtl/sdo_segmented_upload_server.sv
`timescale 1ns/10ps
// Operation
// - requests on 600h+node, answers on 580h+node
// - index LSB first in bytes 1-2, subindex byte 3
// - string subindex n returns character n expedited
// - string subindex 00 switches to segmented upload
// - segmented initiate answer 41h, length in data
// - toggle alternates, starts 0 every transfer
// - segment answer echoes request toggle
// - three-bit count of invalid trailing bytes
// - last-segment flag set only on final segment
// - up to seven data bytes per segment
// - abort frame 80h, index, subindex, code
// - abort ends transfer unconfirmed, restart fresh
// - received abort code is ignored
// - unchanged toggle aborts with 05030000
// - disallowed command aborts with 05040001
// - read-only write 06010002, complete access 06010000
// - missing index 06020000, missing subindex 06090011
// - write too long 06070012, too short 06070013
// - not mappable 06040041, over 8 bytes 06040042
// - above range 06090031, below range 06090032
// - operational state blocks PDO parameter writes 08000022
// - other failures abort with 08000000
module sdo_segmented_upload_server (
  // clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // configuration
  input wire logic [6:0] node_id,
  input wire logic nmt_operational,
  // received frames
  input wire logic rx_valid,
  input wire sdo_pkg::can_frame_t rx_frame,
  output logic rx_ready,
  // frames to send
  output logic tx_valid,
  input wire logic tx_ready,
  output sdo_pkg::can_frame_t tx_frame,
  // object dictionary query
  output logic [15:0] od_index,
  output logic [7:0] od_subindex,
  input wire sdo_pkg::od_info_t od_info,
  output logic [7:0] od_char_addr,
  input wire logic [7:0] od_char,
  // object dictionary write
  output logic od_wr,
  output logic [31:0] od_wr_data,
  output logic [2:0] od_wr_len
);

  sdo_pkg::state_t state_reg, state_next;
  sdo_pkg::can_frame_t req_reg, req_next;
  sdo_pkg::can_frame_t tx_reg, tx_next;
  logic seg_active_reg, seg_active_next;
  logic toggle_reg, toggle_next;
  logic [7:0] seg_pos_reg, seg_pos_next;
  logic [7:0] seg_len_reg, seg_len_next;
  logic [15:0] seg_index_reg, seg_index_next;
  logic [7:0] seg_sub_reg, seg_sub_next;
  logic [2:0] fill_cnt_reg, fill_cnt_next;
  logic [7:0] char_addr_reg, char_addr_next;
  logic wr_reg, wr_next;
  logic [31:0] wr_data_reg, wr_data_next;
  logic [2:0] wr_len_reg, wr_len_next;

  logic [7:0] cmd;
  logic [15:0] req_index;
  logic [7:0] req_sub;
  logic [2:0] dl_len;
  logic is_pdo_param;
  logic rx_addressed;

  assign cmd = req_reg.data[0];
  assign req_index = {req_reg.data[2], req_reg.data[1]};
  assign req_sub = req_reg.data[3];
  assign dl_len = sdo_pkg::EXP_MAX_BYTES - {1'b0, cmd[3:2]};
  assign is_pdo_param = (req_index[15:8] == sdo_pkg::PDO_RX_COMM || req_index[15:8] == sdo_pkg::PDO_RX_MAP ||
                         req_index[15:8] == sdo_pkg::PDO_TX_COMM || req_index[15:8] == sdo_pkg::PDO_TX_MAP) &&
                        (req_index[7:0] < sdo_pkg::PDO_GROUP_COUNT);
  assign rx_addressed = rx_frame.id == sdo_pkg::REQ_ID_BASE + {4'h0, node_id};

  assign rx_ready = state_reg == sdo_pkg::ST_IDLE;
  assign tx_valid = state_reg == sdo_pkg::ST_SEND;
  assign tx_frame = tx_reg;
  assign od_index = req_index;
  assign od_subindex = req_sub;
  assign od_char_addr = char_addr_reg;
  assign od_wr = wr_reg;
  assign od_wr_data = wr_data_reg;
  assign od_wr_len = wr_len_reg;

  // answer frame with the command, payload, index and subindex handed in by the caller
  function automatic sdo_pkg::can_frame_t reply(input logic [7:0] c, input logic [31:0] payload,
                                                input logic [15:0] idx, input logic [7:0] sub,
                                                input logic [6:0] node);
    sdo_pkg::can_frame_t f;
    f.id = sdo_pkg::RSP_ID_BASE + {4'h0, node};
    f.data[0] = c;
    f.data[1] = idx[7:0];
    f.data[2] = idx[15:8];
    f.data[3] = sub;
    f.data[4] = payload[7:0];
    f.data[5] = payload[15:8];
    f.data[6] = payload[23:16];
    f.data[7] = payload[31:24];
    return f;
  endfunction : reply

  always_comb begin
    state_next = state_reg;
    req_next = req_reg;
    tx_next = tx_reg;
    seg_active_next = seg_active_reg;
    toggle_next = toggle_reg;
    seg_pos_next = seg_pos_reg;
    seg_len_next = seg_len_reg;
    seg_index_next = seg_index_reg;
    seg_sub_next = seg_sub_reg;
    fill_cnt_next = fill_cnt_reg;
    char_addr_next = char_addr_reg;
    wr_next = 1'b0;
    wr_data_next = wr_data_reg;
    wr_len_next = wr_len_reg;
    unique case (state_reg)
      sdo_pkg::ST_IDLE: begin
        if (rx_valid && rx_addressed) begin
          req_next = rx_frame;
          state_next = sdo_pkg::ST_EXEC;
        end
      end
      sdo_pkg::ST_EXEC: begin
        state_next = sdo_pkg::ST_SEND;
        if (cmd == sdo_pkg::CMD_ABORT) begin
          // code in bytes 4-7 deliberately unused
          seg_active_next = 1'b0;
          toggle_next = 1'b0;
          state_next = sdo_pkg::ST_IDLE;
        end else if ((cmd[7:5] == sdo_pkg::CCS_UPLOAD || cmd[7:5] == sdo_pkg::CCS_DOWNLOAD) &&
                     cmd[sdo_pkg::COMPLETE_POS]) begin
          tx_next = reply(sdo_pkg::CMD_ABORT, sdo_pkg::ERR_COMPLETE, req_index, req_sub, node_id);
        end else if (cmd[7:5] == sdo_pkg::CCS_SEG_UPLOAD && cmd[3:0] == 4'h0) begin
          if (!seg_active_reg) begin
            tx_next = reply(sdo_pkg::CMD_ABORT, sdo_pkg::ERR_COMMAND, req_index, req_sub, node_id);
          end else if (cmd[sdo_pkg::TOGGLE_POS] != toggle_reg) begin
            tx_next = reply(sdo_pkg::CMD_ABORT, sdo_pkg::ERR_TOGGLE, seg_index_reg, seg_sub_reg, node_id);
            seg_active_next = 1'b0;
            toggle_next = 1'b0;
          end else begin
            tx_next = reply(8'h00, 32'h0, 16'h0, 8'h00, node_id);
            fill_cnt_next = 3'h0;
            char_addr_next = seg_pos_reg;
            state_next = sdo_pkg::ST_FILL;
          end
        end else if (cmd == sdo_pkg::CMD_UP_INIT) begin
          seg_active_next = 1'b0;
          toggle_next = 1'b0;
          if (!od_info.index_ok) begin
            tx_next = reply(sdo_pkg::CMD_ABORT, sdo_pkg::ERR_NO_OBJECT, req_index, req_sub, node_id);
          end else if (od_info.is_string && req_sub == 8'h00) begin
            tx_next = reply(sdo_pkg::CMD_UP_INIT_SEG, {24'h0, od_info.str_len}, req_index, req_sub,
                            node_id);
            seg_active_next = 1'b1;
            seg_pos_next = 8'h00;
            seg_len_next = od_info.str_len;
            seg_index_next = req_index;
            seg_sub_next = req_sub;
          end else if (od_info.is_string) begin
            if (req_sub > od_info.str_len) begin
              tx_next = reply(sdo_pkg::CMD_ABORT, sdo_pkg::ERR_NO_SUBINDEX, req_index, req_sub, node_id);
            end else begin
              char_addr_next = req_sub - 8'h01;
              state_next = sdo_pkg::ST_CHAR;
            end
          end else if (!od_info.sub_ok) begin
            tx_next = reply(sdo_pkg::CMD_ABORT, sdo_pkg::ERR_NO_SUBINDEX, req_index, req_sub, node_id);
          end else if (od_info.fail || od_info.size == 3'h0 || od_info.size > sdo_pkg::EXP_MAX_BYTES) begin
            tx_next = reply(sdo_pkg::CMD_ABORT, sdo_pkg::ERR_GENERAL, req_index, req_sub, node_id);
          end else begin
            tx_next = reply(sdo_pkg::CMD_UP_EXP_BASE | {4'h0, sdo_pkg::EXP_MAX_BYTES[1:0] - od_info.size[1:0],
                            2'b00}, od_info.value, req_index, req_sub, node_id);
          end
        end else if (cmd[7:5] == sdo_pkg::CCS_DOWNLOAD && cmd[1:0] == 2'b11) begin
          seg_active_next = 1'b0;
          toggle_next = 1'b0;
          if (!od_info.index_ok) begin
            tx_next = reply(sdo_pkg::CMD_ABORT, sdo_pkg::ERR_NO_OBJECT, req_index, req_sub, node_id);
          end else if (!od_info.sub_ok) begin
            tx_next = reply(sdo_pkg::CMD_ABORT, sdo_pkg::ERR_NO_SUBINDEX, req_index, req_sub, node_id);
          end else if (!od_info.writable) begin
            tx_next = reply(sdo_pkg::CMD_ABORT, sdo_pkg::ERR_READ_ONLY, req_index, req_sub, node_id);
          end else if (dl_len > od_info.size) begin
            tx_next = reply(sdo_pkg::CMD_ABORT, sdo_pkg::ERR_TOO_LONG, req_index, req_sub, node_id);
          end else if (dl_len < od_info.size) begin
            tx_next = reply(sdo_pkg::CMD_ABORT, sdo_pkg::ERR_TOO_SHORT, req_index, req_sub, node_id);
          end else if (is_pdo_param && nmt_operational) begin
            tx_next = reply(sdo_pkg::CMD_ABORT, sdo_pkg::ERR_STATE, req_index, req_sub, node_id);
          end else if (od_info.not_mappable) begin
            tx_next = reply(sdo_pkg::CMD_ABORT, sdo_pkg::ERR_NOT_MAPPABLE, req_index, req_sub, node_id);
          end else if (od_info.map_overflow) begin
            tx_next = reply(sdo_pkg::CMD_ABORT, sdo_pkg::ERR_MAP_LENGTH, req_index, req_sub, node_id);
          end else if (od_info.too_high) begin
            tx_next = reply(sdo_pkg::CMD_ABORT, sdo_pkg::ERR_TOO_HIGH, req_index, req_sub, node_id);
          end else if (od_info.too_low) begin
            tx_next = reply(sdo_pkg::CMD_ABORT, sdo_pkg::ERR_TOO_LOW, req_index, req_sub, node_id);
          end else if (od_info.fail) begin
            tx_next = reply(sdo_pkg::CMD_ABORT, sdo_pkg::ERR_GENERAL, req_index, req_sub, node_id);
          end else begin
            tx_next = reply(sdo_pkg::CMD_DL_ACK, 32'h0, req_index, req_sub, node_id);
            wr_next = 1'b1;
            wr_data_next = {req_reg.data[7], req_reg.data[6], req_reg.data[5], req_reg.data[4]};
            wr_len_next = dl_len;
          end
        end else begin
          tx_next = reply(sdo_pkg::CMD_ABORT, sdo_pkg::ERR_COMMAND, req_index, req_sub, node_id);
          seg_active_next = 1'b0;
          toggle_next = 1'b0;
        end
      end
      sdo_pkg::ST_CHAR: begin
        // one character, expedited, one valid byte
        tx_next = reply(sdo_pkg::CMD_UP_EXP_BASE | 8'h0c, {24'h0, od_char}, req_index, req_sub, node_id);
        state_next = sdo_pkg::ST_SEND;
      end
      sdo_pkg::ST_FILL: begin
        if (fill_cnt_reg == sdo_pkg::SEG_BYTES || seg_pos_reg == seg_len_reg) begin
          tx_next.data[0] = 8'h00;
          tx_next.data[0][sdo_pkg::TOGGLE_POS] = toggle_reg;
          tx_next.data[0][sdo_pkg::COUNT_LSB +: 3] = sdo_pkg::SEG_BYTES - fill_cnt_reg;
          tx_next.data[0][sdo_pkg::LAST_POS] = seg_pos_reg == seg_len_reg;
          toggle_next = ~toggle_reg;
          if (seg_pos_reg == seg_len_reg) begin
            seg_active_next = 1'b0;
            toggle_next = 1'b0;
          end
          state_next = sdo_pkg::ST_SEND;
        end else begin
          tx_next.data[fill_cnt_reg + 3'h1] = od_char;
          fill_cnt_next = fill_cnt_reg + 3'h1;
          seg_pos_next = seg_pos_reg + 8'h01;
          char_addr_next = seg_pos_reg + 8'h01;
        end
      end
      sdo_pkg::ST_SEND: begin
        if (tx_ready) begin
          state_next = sdo_pkg::ST_IDLE;
        end
      end
      default: begin
        state_next = sdo_pkg::ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= sdo_pkg::ST_IDLE;
      req_reg <= '0;
      tx_reg <= '0;
      seg_active_reg <= 1'b0;
      toggle_reg <= 1'b0;
      seg_pos_reg <= 8'h00;
      seg_len_reg <= 8'h00;
      seg_index_reg <= 16'h0000;
      seg_sub_reg <= 8'h00;
      fill_cnt_reg <= 3'h0;
      char_addr_reg <= 8'h00;
      wr_reg <= 1'b0;
      wr_data_reg <= 32'h0;
      wr_len_reg <= 3'h0;
    end else begin
      state_reg <= state_next;
      req_reg <= req_next;
      tx_reg <= tx_next;
      seg_active_reg <= seg_active_next;
      toggle_reg <= toggle_next;
      seg_pos_reg <= seg_pos_next;
      seg_len_reg <= seg_len_next;
      seg_index_reg <= seg_index_next;
      seg_sub_reg <= seg_sub_next;
      fill_cnt_reg <= fill_cnt_next;
      char_addr_reg <= char_addr_next;
      wr_reg <= wr_next;
      wr_data_reg <= wr_data_next;
      wr_len_reg <= wr_len_next;
    end
  end

endmodule : sdo_segmented_upload_server

// file: rtl/sdo_pkg.sv
package sdo_pkg;

  // message identifiers, node number added on top
  localparam logic [10:0] REQ_ID_BASE = 11'h600;
  localparam logic [10:0] RSP_ID_BASE = 11'h580;

  // command bytes
  localparam logic [7:0] CMD_UP_INIT = 8'h40;
  localparam logic [7:0] CMD_UP_INIT_SEG = 8'h41;
  localparam logic [7:0] CMD_UP_EXP_BASE = 8'h43;
  localparam logic [7:0] CMD_DL_ACK = 8'h60;
  localparam logic [7:0] CMD_ABORT = 8'h80;
  localparam logic [2:0] CCS_DOWNLOAD = 3'h1;
  localparam logic [2:0] CCS_UPLOAD = 3'h2;
  localparam logic [2:0] CCS_SEG_UPLOAD = 3'h3;

  // command byte field positions
  localparam int TOGGLE_POS = 4;
  localparam int COMPLETE_POS = 4;
  localparam int COUNT_LSB = 1;
  localparam int LAST_POS = 0;

  // segment payload
  localparam logic [2:0] SEG_BYTES = 3'h7;
  localparam logic [2:0] EXP_MAX_BYTES = 3'h4;

  // process data object parameter groups, index high byte, count per group
  localparam logic [7:0] PDO_RX_COMM = 8'h14;
  localparam logic [7:0] PDO_RX_MAP = 8'h16;
  localparam logic [7:0] PDO_TX_COMM = 8'h18;
  localparam logic [7:0] PDO_TX_MAP = 8'h1a;
  localparam logic [7:0] PDO_GROUP_COUNT = 8'h08;

  // abort codes
  localparam logic [31:0] ERR_TOGGLE = 32'h05030000;
  localparam logic [31:0] ERR_COMMAND = 32'h05040001;
  localparam logic [31:0] ERR_COMPLETE = 32'h06010000;
  localparam logic [31:0] ERR_READ_ONLY = 32'h06010002;
  localparam logic [31:0] ERR_NO_OBJECT = 32'h06020000;
  localparam logic [31:0] ERR_NOT_MAPPABLE = 32'h06040041;
  localparam logic [31:0] ERR_MAP_LENGTH = 32'h06040042;
  localparam logic [31:0] ERR_TOO_LONG = 32'h06070012;
  localparam logic [31:0] ERR_TOO_SHORT = 32'h06070013;
  localparam logic [31:0] ERR_NO_SUBINDEX = 32'h06090011;
  localparam logic [31:0] ERR_TOO_HIGH = 32'h06090031;
  localparam logic [31:0] ERR_TOO_LOW = 32'h06090032;
  localparam logic [31:0] ERR_GENERAL = 32'h08000000;
  localparam logic [31:0] ERR_STATE = 32'h08000022;

  typedef struct packed {
    logic [10:0] id;
    logic [7:0][7:0] data;
  } can_frame_t;

  // object dictionary answer for the entry on the query ports
  typedef struct packed {
    logic index_ok;
    logic sub_ok;
    logic writable;
    logic is_string;
    logic [2:0] size;
    logic [7:0] str_len;
    logic [31:0] value;
    logic not_mappable;
    logic map_overflow;
    logic too_high;
    logic too_low;
    logic fail;
  } od_info_t;

  typedef enum logic [4:0] {
    ST_IDLE = 5'b00001,
    ST_EXEC = 5'b00010,
    ST_CHAR = 5'b00100,
    ST_FILL = 5'b01000,
    ST_SEND = 5'b10000
  } state_t;

endpackage : sdo_pkg

// file: test/sdo_upload_properties.sv
`timescale 1ns/10ps
module sdo_upload_properties (
  // clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // configuration
  input wire logic [6:0] node_id,
  input wire logic nmt_operational,
  // frames
  input wire logic rx_valid,
  input wire sdo_pkg::can_frame_t rx_frame,
  input wire logic rx_ready,
  input wire logic tx_valid,
  input wire logic tx_ready,
  input wire sdo_pkg::can_frame_t tx_frame,
  // dictionary
  input wire logic [15:0] od_index,
  input wire logic [7:0] od_subindex,
  input wire sdo_pkg::od_info_t od_info,
  input wire logic [7:0] od_char_addr,
  input wire logic [7:0] od_char,
  input wire logic od_wr,
  input wire logic [31:0] od_wr_data,
  input wire logic [2:0] od_wr_len
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);
  logic take;
  logic tog_reg;
  logic [23:0] key_reg;
  assign take = rx_valid && rx_ready && rx_frame.id == sdo_pkg::REQ_ID_BASE + node_id;
  // toggle and index of the request being answered
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      tog_reg <= 1'b0;
      key_reg <= 24'h0;
    end else if (take) begin
      tog_reg <= rx_frame.data[0][4];
      key_reg <= {rx_frame.data[3], rx_frame.data[2], rx_frame.data[1]};
    end
  end
  sequence s_take(logic [7:0] c);
    take && rx_frame.data[0] == c;
  endsequence
  sequence s_seg_answer;
    tx_valid && tx_frame.data[0][7:5] == 3'h0;
  endsequence
  property p_rsp_id;
    tx_valid |-> tx_frame.id == sdo_pkg::RSP_ID_BASE + node_id;
  endproperty
  a_rsp_id: assert property (p_rsp_id) else $error("answer identifier wrong");
  property p_hold;
    tx_valid && !tx_ready |=> tx_valid && $stable(tx_frame);
  endproperty
  a_hold: assert property (p_hold) else $error("answer changed before taken");
  property p_busy;
    take && rx_frame.data[0] != sdo_pkg::CMD_ABORT |=> !rx_ready [*2];
  endproperty
  a_busy: assert property (p_busy) else $error("request taken while busy");
  property p_init_time;
    s_take(sdo_pkg::CMD_UP_INIT) |=> !tx_valid ##[1:2] tx_valid;
  endproperty
  a_init_time: assert property (p_init_time) else $error("upload answer late");
  property p_abort_silent;
    s_take(sdo_pkg::CMD_ABORT) |=> !tx_valid [*4];
  endproperty
  a_abort_silent: assert property (p_abort_silent) else $error("received abort answered");
  property p_count;
    s_seg_answer and !tx_frame.data[0][0] |-> tx_frame.data[0][3:1] == 3'h0;
  endproperty
  a_count: assert property (p_count) else $error("short segment not last");
  property p_toggle;
    s_seg_answer |-> tx_frame.data[0][4] == tog_reg;
  endproperty
  a_toggle: assert property (p_toggle) else $error("segment toggle not echoed");
  property p_echo;
    tx_valid && tx_frame.data[0][7:5] != 3'h0 |-> {tx_frame.data[3], tx_frame.data[2], tx_frame.data[1]} == key_reg;
  endproperty
  a_echo: assert property (p_echo) else $error("index not echoed");
  property p_wr;
    od_wr |-> tx_valid && !$past(tx_valid) ##1 !od_wr;
  endproperty
  a_wr: assert property (p_wr) else $error("write strobe misplaced");
endmodule : sdo_upload_properties

// file: test/od_model.sv
`timescale 1ns/10ps
module od_model #(
  parameter int STR_LEN = 17
) (
  // query
  input wire logic [15:0] od_index,
  input wire logic [7:0] od_subindex,
  input wire logic [7:0] od_char_addr,
  input wire logic [31:0] wr_value,
  // answer
  output sdo_pkg::od_info_t od_info,
  output logic [7:0] od_char
);
  always_comb begin
    od_info = '0;
    od_info.index_ok = 1'b1;
    case (od_index)
      16'h100a: begin
        od_info.sub_ok = 1'b1;
        od_info.is_string = 1'b1;
        od_info.str_len = 8'(STR_LEN);
      end
      16'h6041: begin
        od_info.sub_ok = od_subindex == 8'h00;
        od_info.size = 3'h2;
        od_info.value = 32'h1234;
      end
      16'h1003: begin
        od_info.sub_ok = od_subindex == 8'h00;
        od_info.writable = 1'b1;
        od_info.size = 3'h1;
        od_info.too_high = wr_value != 32'h0;
      end
      16'h1400, 16'h1600: begin
        od_info.sub_ok = od_subindex < 8'h09;
        od_info.writable = 1'b1;
        od_info.size = 3'h4;
        od_info.not_mappable = od_index[9] && wr_value[31:16] == 16'h0;
        od_info.map_overflow = od_index[9] && wr_value[7:0] > 8'h40;
      end
      16'h2000: begin
        od_info.sub_ok = od_subindex < 8'h02;
        od_info.writable = 1'b1;
        od_info.size = 3'h2;
        od_info.too_low = wr_value[15:0] < 16'h0010;
        od_info.fail = od_subindex == 8'h01;
      end
      default: od_info.index_ok = 1'b0;
    endcase
  end
  assign od_char = (od_char_addr < 8'(STR_LEN)) ? 8'h30 + od_char_addr : 8'h00;
endmodule : od_model

// file: test/tb_top.sv
`timescale 1ns/10ps
module tb_top;
  localparam int STR_LEN = 17;
  localparam logic [15:0] STR = 16'h100a;
  logic clock = 1'b0;
  logic rst_n = 1'b0;
  logic [6:0] node_id = 7'h03;
  logic nmt_operational = 1'b0;
  logic rx_valid = 1'b0;
  logic tx_ready = 1'b0;
  sdo_pkg::can_frame_t rx_frame = '0;
  sdo_pkg::can_frame_t tx_frame;
  sdo_pkg::od_info_t od_info;
  logic rx_ready, tx_valid, od_wr;
  logic [15:0] od_index;
  logic [7:0] od_subindex, od_char_addr, od_char;
  logic [31:0] od_wr_data;
  logic [2:0] od_wr_len;
  logic [10:0] req_id;
  logic [35:0] wr_seen;
  logic [31:0] seed = 32'h45d0;
  int mismatches = 0;
  int compares = 0;
  int cycles = 0;
  always #12.5 clock = ~clock;
  sdo_segmented_upload_server dut (.clock(clock), .rst_n(rst_n), .node_id(node_id),
    .nmt_operational(nmt_operational), .rx_valid(rx_valid), .rx_frame(rx_frame), .rx_ready(rx_ready),
    .tx_valid(tx_valid), .tx_ready(tx_ready), .tx_frame(tx_frame), .od_index(od_index),
    .od_subindex(od_subindex), .od_info(od_info), .od_char_addr(od_char_addr), .od_char(od_char),
    .od_wr(od_wr), .od_wr_data(od_wr_data), .od_wr_len(od_wr_len));
  od_model #(.STR_LEN(STR_LEN)) dict (.od_index(od_index), .od_subindex(od_subindex),
    .od_char_addr(od_char_addr), .wr_value(rx_frame.data[7:4]), .od_info(od_info), .od_char(od_char));
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr
  function automatic logic [63:0] mk(input logic [7:0] c, input logic [15:0] i, input logic [7:0] s,
    input logic [31:0] v);
    return {v, s, i, c};
  endfunction : mk
  function automatic logic [7:0] chr(input int a);
    return (a < STR_LEN) ? 8'h30 + 8'(a) : 8'h00;
  endfunction : chr
  function automatic logic [63:0] seg_exp(input int off, input logic t);
    logic [63:0] e;
    int v;
    v = (STR_LEN - off > 7) ? 7 : STR_LEN - off;
    e[7:0] = {3'h0, t, 3'(7 - v), 1'(off + 7 >= STR_LEN)};
    for (int i = 1; i < 8; i++) e[i * 8 +: 8] = chr(off + i - 1);
    return e;
  endfunction : seg_exp
  task automatic cmp(input string what, input logic [63:0] exp, input logic [63:0] got);
    compares++;
    if (got !== exp) begin
      mismatches++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask : cmp
  task automatic tally_and_finish;
    $display("compares %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : tally_and_finish
  // one request; source holds it until taken, answer stalled at random
  task automatic run(input logic [63:0] req, input logic [63:0] exp, input bit op, input bit ans);
    int n;
    @(posedge clock);
    rx_frame <= {req_id, req};
    rx_valid <= 1'b1;
    nmt_operational <= op;
    do @(negedge clock); while (rx_ready !== 1'b1);
    @(posedge clock);
    rx_valid <= 1'b0;
    n = 0;
    do begin
      @(negedge clock);
      n++;
    end while (tx_valid !== 1'b1 && n < 16);
    wr_seen = {od_wr, od_wr_len, od_wr_data};
    cmp("tx_valid", 64'(ans), 64'(tx_valid));
    if (ans) begin
      repeat (seed[1:0]) @(negedge clock);
      seed = lfsr(seed);
      cmp("id", 64'(sdo_pkg::RSP_ID_BASE + 11'(node_id)), 64'(tx_frame.id));
      cmp("answer", exp, tx_frame.data);
      @(posedge clock);
      tx_ready <= 1'b1;
      @(posedge clock);
      tx_ready <= 1'b0;
    end
  endtask : run
  task automatic ab(input logic [7:0] c, input logic [15:0] i, input logic [7:0] s, input logic [31:0] v,
    input bit op, input logic [31:0] code);
    run(mk(c, i, s, v), mk(sdo_pkg::CMD_ABORT, i, s, code), op, 1);
  endtask : ab
  task automatic init_up;
    run(mk(8'h40, STR, 8'h00, 32'h0), mk(8'h41, STR, 8'h00, 32'(STR_LEN)), 0, 1);
  endtask : init_up
  task automatic seg(input int off, input bit t);
    run(mk(t ? 8'h70 : 8'h60, STR, 8'h00, 32'h0), seg_exp(off, t), 0, 1);
  endtask : seg
  always @(posedge clock) begin
    cycles++;
    if (cycles > 6000) begin
      mismatches++;
      tally_and_finish;
    end
  end
  initial begin
    logic [7:0] k;
    repeat (5) @(posedge clock);
    rst_n <= 1'b1;
    node_id <= 7'h01 + 7'(seed[5:0]);
    seed = lfsr(seed);
    @(posedge clock);
    req_id = sdo_pkg::REQ_ID_BASE + 11'(node_id);
    init_up;
    seg(0, 0);
    ab(8'h60, STR, 8'h00, 32'h0, 0, sdo_pkg::ERR_TOGGLE);
    init_up;
    seg(0, 0);
    run(mk(sdo_pkg::CMD_ABORT, STR, 8'h00, seed), 64'h0, 0, 0);
    ab(8'h70, STR, 8'h00, 32'h0, 0, sdo_pkg::ERR_COMMAND);
    repeat (2) begin
      init_up;
      for (int s = 0; s < 3; s++) seg(7 * s, s[0]);
    end
    for (int j = 0; j < 5; j++) begin
      k = (j == 0) ? 8'(STR_LEN) : 8'h01 + 8'(seed % 32'(STR_LEN));
      seed = lfsr(seed);
      run(mk(8'h40, STR, k, 32'h0), mk(8'h4f, STR, k, 32'(chr(k - 1))), 0, 1);
    end
    ab(8'h40, STR, 8'(STR_LEN + 1), 32'h0, 0, sdo_pkg::ERR_NO_SUBINDEX);
    req_id = req_id + 11'h001;
    run(mk(8'h40, 16'h6041, 8'h00, 32'h0), 64'h0, 0, 0);
    req_id = req_id - 11'h001;
    run(mk(8'h40, 16'h6041, 8'h00, 32'h0), mk(8'h4b, 16'h6041, 8'h00, 32'h1234), 0, 1);
    ab(8'h23, 16'h6041, 8'h00, 32'h0, 0, sdo_pkg::ERR_READ_ONLY);
    ab(8'h50, 16'h6041, 8'h00, 32'h0, 0, sdo_pkg::ERR_COMPLETE);
    ab(8'he0, 16'h6041, 8'h00, 32'h0, 0, sdo_pkg::ERR_COMMAND);
    ab(8'h40, 16'h7777, 8'h00, 32'h0, 0, sdo_pkg::ERR_NO_OBJECT);
    ab(8'h40, 16'h6041, 8'h01, 32'h0, 0, sdo_pkg::ERR_NO_SUBINDEX);
    ab(8'h2b, 16'h1003, 8'h00, 32'h0, 0, sdo_pkg::ERR_TOO_LONG);
    ab(8'h2f, 16'h1400, 8'h01, 32'h0, 0, sdo_pkg::ERR_TOO_SHORT);
    ab(8'h23, 16'h1400, 8'h01, 32'h0, 1, sdo_pkg::ERR_STATE);
    ab(8'h23, 16'h1600, 8'h01, 32'h8, 0, sdo_pkg::ERR_NOT_MAPPABLE);
    ab(8'h23, 16'h1600, 8'h01, 32'h60400050, 0, sdo_pkg::ERR_MAP_LENGTH);
    ab(8'h2f, 16'h1003, 8'h00, 32'h5, 0, sdo_pkg::ERR_TOO_HIGH);
    ab(8'h2b, 16'h2000, 8'h00, 32'h5, 0, sdo_pkg::ERR_TOO_LOW);
    ab(8'h2b, 16'h2000, 8'h01, 32'h20, 0, sdo_pkg::ERR_GENERAL);
    cmp("od_wr refused", 64'h0, 64'(wr_seen));
    run(mk(8'h2f, 16'h1003, 8'h00, 32'h0), mk(8'h60, 16'h1003, 8'h00, 32'h0), 0, 1);
    cmp("od_wr", 64'({1'b1, 3'h1, 32'h0}), 64'(wr_seen));
    run(mk(8'h2b, 16'h2000, 8'h00, 32'h1234), mk(8'h60, 16'h2000, 8'h00, 32'h0), 0, 1);
    cmp("od_wr", 64'({1'b1, 3'h2, 32'h1234}), 64'(wr_seen));
    tally_and_finish;
  end
endmodule : tb_top
bind sdo_segmented_upload_server sdo_upload_properties chk (.clock(clock), .rst_n(rst_n), .node_id(node_id),
  .nmt_operational(nmt_operational), .rx_valid(rx_valid), .rx_frame(rx_frame), .rx_ready(rx_ready),
  .tx_valid(tx_valid), .tx_ready(tx_ready), .tx_frame(tx_frame), .od_index(od_index),
  .od_subindex(od_subindex), .od_info(od_info), .od_char_addr(od_char_addr), .od_char(od_char),
  .od_wr(od_wr), .od_wr_data(od_wr_data), .od_wr_len(od_wr_len));
